// File: nips_map.vh
// Constants for the normal input sharing block: word numbers, filter codes, timing counts.
// Assumes a 125 MHz clock; included by nips_top.v only.
// Overview of operation
// - Normal inputs latch into memory only at refresh
// - Configurable on/off filter precedes the capture
// - Filter: none, 0.5 to 32 ms, default 8
// - Bits 00-09 of two words, first 2960
// - Setup configuration selects normal input terminals
// - Immediate refresh instruction never updates these bits
// - Each terminal routes to exactly one function
// - Terminal two normal disables quick, interrupt, origin
// - Terminal two counter choice: counter 1 Z/reset
`ifndef NIPS_MAP_VH
`define NIPS_MAP_VH

`define NIPS_CLK_MHZ 125
`define NIPS_WORD_MOD0 16'd2960
`define NIPS_WORD_MOD1 16'd2962
`define NIPS_BITS_PER_WORD 10
`define NIPS_BIT_TERM2 2

// Filter selection codes
`define NIPS_FLT_NONE 3'h0
`define NIPS_FLT_0M5 3'h1
`define NIPS_FLT_1M 3'h2
`define NIPS_FLT_2M 3'h3
`define NIPS_FLT_4M 3'h4
`define NIPS_FLT_8M 3'h5
`define NIPS_FLT_16M 3'h6
`define NIPS_FLT_32M 3'h7
`define NIPS_FLT_DEFAULT `NIPS_FLT_8M

// Base filter time 0.5 ms = 500 us; larger settings are powers of two of it
`define NIPS_FLT_BASE_US 500
`define NIPS_FLT_BASE_CYC 24'd62500

// Terminal function codes (one-hot)
`define NIPS_FN_NORMAL 5'h01
`define NIPS_FN_QUICK 5'h02
`define NIPS_FN_INTR 5'h04
`define NIPS_FN_COUNTER 5'h08
`define NIPS_FN_ORIGIN 5'h10

`endif

// File: nips_top.v
// Normal input capture with filter, refresh latching and terminal function routing.
// Assumes field pins are asynchronous; refresh pulse comes from the controller scan logic.
`timescale 1ns/1ps
`default_nettype none
`include "nips_map.vh"

module nips_top #(
	parameter NTERM = 20,
	parameter [23:0] BASE_CYC = `NIPS_FLT_BASE_CYC
) (
	// Clock and reset
	input wire clk,
	input wire rst,
	// Field pins, module 0 terminals 0-9 then module 1 terminals 10-19
	input wire [NTERM-1:0] input_terminal_pins,
	// Setup configuration: filter code and one-hot function per terminal
	input wire [2:0] filter_sel,
	input wire filter_sel_valid,
	input wire [5*NTERM-1:0] term_function,
	// Refresh strobes from the scan logic
	input wire io_refresh,
	input wire immediate_refresh_instruction,
	// Input memory words
	output reg [15:0] word_mod0_r,
	output reg [15:0] word_mod1_r,
	output reg [15:0] word_mod0_addr_r,
	output reg [15:0] word_mod1_addr_r,
	// Routed alternate functions
	output reg [NTERM-1:0] quick_in_r,
	output reg [NTERM-1:0] intr_in_r,
	output reg [NTERM-1:0] origin_in_r,
	output reg [NTERM-1:0] counter_in_r,
	output reg counter1_zreset_r,
	output reg [NTERM-1:0] cfg_conflict_r
);

	wire [NTERM-1:0] sync2_r;
	wire [NTERM-1:0] filt_r;
	reg bypass;
	reg [NTERM-1:0] normal_en;
	reg [NTERM-1:0] quick_en;
	reg [NTERM-1:0] intr_en;
	reg [NTERM-1:0] cnt_en;
	reg [NTERM-1:0] org_en;
	reg [NTERM-1:0] bad;
	reg [4:0] fn;
	reg [2:0] sel;
	reg [29:0] limit;
	reg [19:0] mem_nxt;
	integer i;

	// Effective filter setting, default when unconfigured
	always @* begin
		sel = filter_sel_valid ? filter_sel : `NIPS_FLT_DEFAULT;
		limit = ({6'h00, BASE_CYC} << (sel - 3'h1));
		bypass = (sel == `NIPS_FLT_NONE);
	end

	// Decode function selection from setup, never from pin state
	always @* begin
		normal_en = {NTERM{1'b0}};
		quick_en = {NTERM{1'b0}};
		intr_en = {NTERM{1'b0}};
		cnt_en = {NTERM{1'b0}};
		org_en = {NTERM{1'b0}};
		bad = {NTERM{1'b0}};
		fn = 5'h00;
		for (i = 0; i < NTERM; i = i + 1) begin
			fn = term_function[5*i +: 5];
			// Anything not exactly one-hot falls back to a normal input
			case (fn)
				`NIPS_FN_QUICK: quick_en[i] = 1'b1;
				`NIPS_FN_INTR: intr_en[i] = 1'b1;
				`NIPS_FN_COUNTER: cnt_en[i] = 1'b1;
				`NIPS_FN_ORIGIN: org_en[i] = 1'b1;
				`NIPS_FN_NORMAL: normal_en[i] = 1'b1;
				default: begin
					normal_en[i] = 1'b1;
					bad[i] = 1'b1;
				end
			endcase
		end
	end

	// Field pins cross into the clock domain before any logic reads them
	nips_sync #(
		.W(NTERM)
	) sync_u (
		.clk(clk),
		.rst(rst),
		.async_in(input_terminal_pins),
		.sync_r(sync2_r)
	);

	// Per-terminal stability filter
	genvar g;
	generate
		for (g = 0; g < NTERM; g = g + 1) begin : gen_flt
			nips_filter #(
				.CW(30)
			) flt_u (
				.clk(clk),
				.rst(rst),
				.bypass(bypass),
				.limit(limit),
				.level_in(sync2_r[g]),
				.level_r(filt_r[g])
			);
		end
	endgenerate

	// Memory value at refresh: normal bits take filtered level, others read zero
	always @* begin
		mem_nxt = filt_r & normal_en;
	end

	always @(posedge clk) begin
		if (rst) begin
			word_mod0_r <= 16'h0000;
			word_mod1_r <= 16'h0000;
			word_mod0_addr_r <= `NIPS_WORD_MOD0;
			word_mod1_addr_r <= `NIPS_WORD_MOD1;
			quick_in_r <= {NTERM{1'b0}};
			intr_in_r <= {NTERM{1'b0}};
			origin_in_r <= {NTERM{1'b0}};
			counter_in_r <= {NTERM{1'b0}};
			counter1_zreset_r <= 1'b0;
			cfg_conflict_r <= {NTERM{1'b0}};
		end else begin
			word_mod0_addr_r <= `NIPS_WORD_MOD0;
			word_mod1_addr_r <= `NIPS_WORD_MOD1;
			// Immediate refresh is deliberately not a term here
			if (io_refresh) begin
				word_mod0_r <= {6'h00, mem_nxt[9:0]};
				word_mod1_r <= {6'h00, mem_nxt[19:10]};
			end
			// Alternate functions see the synchronised raw pin, unfiltered
			quick_in_r <= sync2_r & quick_en;
			intr_in_r <= sync2_r & intr_en;
			origin_in_r <= sync2_r & org_en;
			counter_in_r <= sync2_r & cnt_en;
			counter1_zreset_r <= sync2_r[`NIPS_BIT_TERM2] & cnt_en[`NIPS_BIT_TERM2];
			cfg_conflict_r <= bad;
		end
	end

endmodule

// Two-stage synchroniser for field levels; only the second stage is read
module nips_sync #(
	parameter W = 20
) (
	// Clock and reset
	input wire clk,
	input wire rst,
	// Asynchronous levels in, synchronised levels out
	input wire [W-1:0] async_in,
	output reg [W-1:0] sync_r
);

	reg [W-1:0] meta_r;

	always @(posedge clk) begin
		if (rst) begin
			meta_r <= {W{1'b0}};
			sync_r <= {W{1'b0}};
		end else begin
			meta_r <= async_in;
			sync_r <= meta_r;
		end
	end

endmodule

// Stability filter for one terminal
// With bypass clear, a level is accepted only after it has differed from the held one for limit cycles in a row
module nips_filter #(
	parameter CW = 30
) (
	// Clock and reset
	input wire clk,
	input wire rst,
	// Filter control
	input wire bypass,
	input wire [CW-1:0] limit,
	// Synchronised level in, accepted level out
	input wire level_in,
	output reg level_r
);

	reg [CW-1:0] cnt_r;
	reg [CW-1:0] cnt_nxt;
	reg [CW-1:0] cnt_inc;
	reg level_nxt;

	always @* begin
		cnt_inc = cnt_r + {{(CW-1){1'b0}}, 1'b1};
		cnt_nxt = cnt_r;
		level_nxt = level_r;
		if (bypass) begin
			cnt_nxt = {CW{1'b0}};
			level_nxt = level_in;
		end else if (level_in == level_r) begin
			// A bounce back to the held level restarts the count
			cnt_nxt = {CW{1'b0}};
		end else if (cnt_inc >= limit) begin
			cnt_nxt = {CW{1'b0}};
			level_nxt = level_in;
		end else begin
			cnt_nxt = cnt_inc;
		end
	end

	always @(posedge clk) begin
		if (rst) begin
			cnt_r <= {CW{1'b0}};
			level_r <= 1'b0;
		end else begin
			cnt_r <= cnt_nxt;
			level_r <= level_nxt;
		end
	end

endmodule
`default_nettype wire

// File: nips_sva.sv
// Checker on nips_top ports: word map, refresh hold, terminal two sharing.
// Assumes one clock domain; bound to every nips_top below.
`timescale 1ns/1ps
`default_nettype none
module nips_sva (
	input wire logic clk, rst, io_refresh, counter1_zreset_r,
	input wire logic [19:0] input_terminal_pins, quick_in_r, intr_in_r, origin_in_r,
	input wire logic [99:0] term_function,
	input wire logic [15:0] word_mod0_r, word_mod1_r, word_mod0_addr_r, word_mod1_addr_r
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	property p_addr; word_mod0_addr_r == 16'd2960 && word_mod1_addr_r == 16'd2962; endproperty
	a_addr: assert property (p_addr) else $error("word numbers wrong");
	property p_top; {word_mod0_r[15:10], word_mod1_r[15:10]} == 12'h000; endproperty
	a_top: assert property (p_top) else $error("unused word bits set");
	property p_hold; !io_refresh |=> $stable({word_mod0_r, word_mod1_r}); endproperty
	a_hold: assert property (p_hold) else $error("word moved off refresh");
	property p_one; (quick_in_r & intr_in_r) == 20'h0 &&
		((quick_in_r | intr_in_r) & origin_in_r) == 20'h0; endproperty
	a_one: assert property (p_one) else $error("two routes at once");
	property p_t2n; (term_function[14:10] == 5'h01) [*4] |->
		{quick_in_r[2], intr_in_r[2], origin_in_r[2]} == 3'h0; endproperty
	a_t2n: assert property (p_t2n) else $error("normal two still routed");
	property p_t2z; (term_function[14:10] == 5'h08 && input_terminal_pins[2]) [*4]
		|-> counter1_zreset_r; endproperty
	a_t2z: assert property (p_t2z) else $error("zreset missing");
	property p_t2q; (term_function[14:10] == 5'h02 && input_terminal_pins[2]) [*4]
		|-> quick_in_r[2]; endproperty
	a_t2q: assert property (p_t2q) else $error("quick missing");
	property p_nn; io_refresh && term_function[14:10] == 5'h08 |=> !word_mod0_r[2]; endproperty
	a_nn: assert property (p_nn) else $error("counter two in word");
	c_ref: cover property (io_refresh);
	c_z: cover property (counter1_zreset_r);
	c_q: cover property (quick_in_r[2]);
endmodule
bind nips_top nips_sva sva_u (.clk(clk), .rst(rst), .io_refresh(io_refresh),
	.counter1_zreset_r(counter1_zreset_r), .input_terminal_pins(input_terminal_pins),
	.quick_in_r(quick_in_r), .intr_in_r(intr_in_r), .origin_in_r(origin_in_r),
	.term_function(term_function), .word_mod0_r(word_mod0_r), .word_mod1_r(word_mod1_r),
	.word_mod0_addr_r(word_mod0_addr_r), .word_mod1_addr_r(word_mod1_addr_r));
`default_nettype wire

// File: nips_field.sv
// Field wiring model: terminal levels with optional contact chatter.
// Assumes the bench sets lvl just after rising edges.
`timescale 1ns/1ps
`default_nettype none
module nips_field (input wire logic clk, chat, input wire logic [19:0] lvl,
	output logic [19:0] pins);
	logic ph = 1'b0;
	always @(posedge clk) ph <= ~ph;
	// Flips every cycle, so no filter may settle on it
	assign pins = (chat && ph) ? ~lvl : lvl;
endmodule
`default_nettype wire

// File: nips_top_tb.sv
// Self-checking bench for nips_top with a four-cycle filter base.
// Assumes nips_field on the pins and the bound checker.
`timescale 1ns/1ps
`default_nettype none
module nips_top_tb;
	logic clk = 0, rst = 1, filter_sel_valid = 1, io_refresh = 0, chat = 0;
	logic immediate_refresh_instruction = 0;
	logic [2:0] filter_sel = 3'h0;
	logic [19:0] lvl = 20'h5a5a5;
	logic [99:0] term_function = {20{5'h01}};
	wire [19:0] input_terminal_pins, quick_in_r, intr_in_r, origin_in_r, counter_in_r;
	wire [19:0] cfg_conflict_r;
	wire [15:0] word_mod0_r, word_mod1_r, word_mod0_addr_r, word_mod1_addr_r;
	wire counter1_zreset_r;
	int n_mismatch = 0;
	int tests_run = 0;
	initial forever #4 clk = ~clk;
	nips_field fld_u (.clk(clk), .chat(chat), .lvl(lvl), .pins(input_terminal_pins));
	nips_top #(.BASE_CYC(24'd4)) dut_u (.clk(clk), .rst(rst),
		.input_terminal_pins(input_terminal_pins), .filter_sel(filter_sel),
		.filter_sel_valid(filter_sel_valid), .term_function(term_function),
		.io_refresh(io_refresh),
		.immediate_refresh_instruction(immediate_refresh_instruction),
		.word_mod0_r(word_mod0_r), .word_mod1_r(word_mod1_r),
		.word_mod0_addr_r(word_mod0_addr_r), .word_mod1_addr_r(word_mod1_addr_r),
		.quick_in_r(quick_in_r), .intr_in_r(intr_in_r), .origin_in_r(origin_in_r),
		.counter_in_r(counter_in_r), .counter1_zreset_r(counter1_zreset_r),
		.cfg_conflict_r(cfg_conflict_r));
	task automatic chk(input string nm, input logic [15:0] seen, exp);
		tests_run++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("[FAIL] %s exp %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic rfr;
		io_refresh = 1;
		tick(1);
		io_refresh = 0;
	endtask
	task automatic conclude;
		$display("checks %0d mismatches %0d", tests_run, n_mismatch);
		if (n_mismatch == 0 && tests_run > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	initial begin
		#20000;
		n_mismatch++;
		conclude;
	end
	initial begin
		tick(5);
		rst = 0;
		chk("addr0", word_mod0_addr_r, 16'd2960);
		chk("addr1", word_mod1_addr_r, 16'd2962);
		tick(6);
		immediate_refresh_instruction = 1;
		tick(1);
		immediate_refresh_instruction = 0;
		chk("imm", word_mod0_r, 16'h0000);
		rfr;
		chk("w0", word_mod0_r, {6'h00, lvl[9:0]});
		chk("w1", word_mod1_r, {6'h00, lvl[19:10]});
		$display("refresh test done");
		filter_sel_valid = 0;
		lvl = ~lvl;
		chat = 1;
		tick(40);
		chat = 0;
		rfr;
		chk("chatter", word_mod0_r, {6'h00, ~lvl[9:0]});
		tick(40);
		rfr;
		chk("early", word_mod0_r, {6'h00, ~lvl[9:0]});
		tick(30);
		rfr;
		chk("late", word_mod0_r, {6'h00, lvl[9:0]});
		$display("filter test done");
		filter_sel_valid = 1;
		term_function[14:0] = {5'h08, 5'h10, 5'h04};
		lvl[2:0] = 3'h7;
		tick(5);
		rfr;
		chk("t2 word", {13'h0000, word_mod0_r[2:0]}, 16'h0000);
		chk("zreset", {15'h0000, counter1_zreset_r}, 16'h0001);
		chk("counter", counter_in_r[15:0], 16'h0004);
		chk("intr", intr_in_r[15:0], 16'h0001);
		chk("origin", origin_in_r[15:0], 16'h0002);
		term_function[14:10] = 5'h02;
		tick(5);
		chk("quick", {15'h0000, quick_in_r[2]}, 16'h0001);
		chk("no z", {15'h0000, counter1_zreset_r}, 16'h0000);
		term_function[14:10] = 5'h03;
		tick(2);
		rfr;
		chk("conflict", cfg_conflict_r[15:0], 16'h0004);
		chk("t2 fallback", {15'h0000, word_mod0_r[2]}, 16'h0001);
		$display("sharing test done");
		filter_sel = 3'h1;
		term_function = {20{5'h01}};
		lvl[2] = 1'b0;
		tick(5);
		rfr;
		chk("fast early", {15'h0000, word_mod0_r[2]}, 16'h0001);
		tick(1);
		rfr;
		chk("fast late", {15'h0000, word_mod0_r[2]}, 16'h0000);
		$display("filter code test done");
		conclude;
	end
endmodule
`default_nettype wire
